// ### inc/frame_sync_consts.svh
// constants for the frame sync resync and output synthesis block
// assumes a 100 MHz system clock and a word-aligned register bus
`ifndef FRAME_SYNC_CONSTS_SVH
`define FRAME_SYNC_CONSTS_SVH
// clock and rate figures
`define SYS_CLK_KHZ 100000
`define FRAME_8K_HZ 8000
`define COMP_64K_HZ 64000
`define RES_6M48_KHZ 6480
`define RES_19M44_KHZ 19440
`define RES_38M88_KHZ 38880
`define CYC_FRAME_8K ((`SYS_CLK_KHZ * 1000) / `FRAME_8K_HZ)
`define FRAMES_PER_2K 4
`define COMP_SLOTS (`COMP_64K_HZ / `FRAME_8K_HZ)
`define CYC_SLOT_SHORT (`CYC_FRAME_8K / `COMP_SLOTS)
`define CYC_RES_6M48 (`SYS_CLK_KHZ / `RES_6M48_KHZ)
`define CYC_RES_19M44 (`SYS_CLK_KHZ / `RES_19M44_KHZ)
`define CYC_RES_38M88 (`SYS_CLK_KHZ / `RES_38M88_KHZ)
// register indices, byte address is four times the index
`define IDX_ALARM_STICKY 8'h08
`define IDX_ALARM_LIVE 8'h09
`define IDX_DIFF_OUT 8'h3a
`define IDX_PBO 8'h48
`define IDX_FRAME_OUT 8'h7a
`define IDX_SYNC_CFG 8'h7b
`define IDX_SYNC_WIN 8'h7c
`define IDX_SYNTH_CFG 8'h50
`define IDX_PHASE_OFS 8'h51
// field positions
`define BIT_ALARM 7
`define BIT_PBO_EN 2
`define BIT_AUX_FRAMES 7
`define BIT_INDEP 7
`define BIT_SYNC_PHASE 6
`define BIT_SYNC_OCN 5
`define LSB_WIN 4
`define BIT_APLL_FROM_LF 3
`define BIT_LF_FROM_APLL 4
`define BIT_PREDIV 5
// reset values
`define RST_DIFF_OUT 8'h02
`define RST_PBO 8'h04
`define RST_FRAME_OUT 8'h00
`define RST_SYNC_CFG 8'h01
`define RST_SYNC_WIN 8'h20
`define RST_SYNTH_CFG 8'h00
`define RST_PHASE_OFS 16'h0000
`endif

// ### inc/frame_sync_pkg.sv
// types shared by the frame sync block
// assumes nothing beyond the constants header
package frame_sync_pkg;
  // input signal detector, gray along absent, qualifying, present
  typedef enum logic [1:0] {
    DET_ABSENT = 2'b00,
    DET_QUAL = 2'b01,
    DET_PRESENT = 2'b11
  } det_state_t;

  // output apll divide code to ratio
  function automatic logic [5:0] div_ratio(input logic [2:0] code);
    case (code)
      3'h0: div_ratio = 6'h01;
      3'h1: div_ratio = 6'h02;
      3'h2: div_ratio = 6'h04;
      3'h3: div_ratio = 6'h06;
      3'h4: div_ratio = 6'h08;
      3'h5: div_ratio = 6'h0c;
      3'h6: div_ratio = 6'h10;
      default: div_ratio = 6'h30;
    endcase
  endfunction
endpackage

// ### rtl/frame_sync_resync.sv
// frame-align resync, frame pulse generation, composite clock and synth controls
// assumes all inputs synchronous to clock_in; reference clock arrives as a level
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`include "frame_sync_consts.svh"
module frame_sync_resync #(
  parameter int QUAL_EDGES = 2,
  parameter logic [31:0] SYNTH_INC = 32'h109c_0cf5
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // avalon-mm slave
  input wire logic [9:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // reference and sync inputs
  input wire logic ref_clk_in,
  input wire logic ref_is_19m44_in,
  input wire logic frame_align_in,
  input wire logic aux_frame_8k_in,
  input wire logic aux_mframe_2k_in,
  // frame pulses
  output logic frame_pulse_8k_out,
  output logic multiframe_pulse_2k_out,
  output logic gco_frame_8k_out,
  output logic gco_mframe_2k_out,
  // composite clock
  output logic ami_pos_out,
  output logic ami_neg_out,
  // synthesized clocks and path controls
  output logic optical_clk_out,
  output logic forward_clk_out,
  output logic [1:0] diff_std_out,
  output logic pbo_enable_out,
  output logic pfd_prediv_out,
  output logic lf_from_apll_out,
  output logic apll_from_lf_out,
  output logic [5:0] apll_div_out,
  output logic alarm_out
);
  localparam int P8 = `CYC_FRAME_8K;
  localparam int P2 = P8 * `FRAMES_PER_2K;
  localparam int SLOT = `CYC_SLOT_SHORT;

  initial
  begin
    if (QUAL_EDGES < 1 || QUAL_EDGES > 15)
      $error("QUAL_EDGES out of range");
  end

  // ---------------- register bus
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic sticky_q, sticky_d;
  logic [7:0] diff_q, diff_d, pbo_q, pbo_d, fout_q, fout_d;
  logic [7:0] scfg_q, scfg_d, swin_q, swin_d, syn_q, syn_d;
  logic [15:0] phofs_q, phofs_d;
  logic live_q;
  logic fail_ev;
  logic [7:0] idx;
  logic take, wr;

  assign idx = address_in[9:2];

  always_comb
  begin
    take = (read_in || write_in) && wait_q;
    // write commits at the edge where the master sees waitrequest low
    wr = write_in && !wait_q;
    wait_d = !take;
    rdata_d = rdata_q;
    diff_d = diff_q;
    pbo_d = pbo_q;
    fout_d = fout_q;
    scfg_d = scfg_q;
    swin_d = swin_q;
    syn_d = syn_q;
    phofs_d = phofs_q;
    sticky_d = sticky_q;
    if (take && read_in)
    begin
      rdata_d = 32'h0000_0000;
      case (idx)
        `IDX_ALARM_STICKY: rdata_d[`BIT_ALARM] = sticky_q;
        `IDX_ALARM_LIVE: rdata_d[`BIT_ALARM] = live_q;
        `IDX_DIFF_OUT: rdata_d[7:0] = diff_q;
        `IDX_PBO: rdata_d[7:0] = pbo_q;
        `IDX_FRAME_OUT: rdata_d[7:0] = fout_q;
        `IDX_SYNC_CFG: rdata_d[7:0] = scfg_q;
        `IDX_SYNC_WIN: rdata_d[7:0] = swin_q;
        `IDX_SYNTH_CFG: rdata_d[7:0] = syn_q;
        `IDX_PHASE_OFS: rdata_d[15:0] = phofs_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (wr && byteenable_in[0])
    begin
      case (idx)
        `IDX_ALARM_STICKY:
          if (writedata_in[`BIT_ALARM])
            sticky_d = 1'b0;
        `IDX_DIFF_OUT: diff_d = writedata_in[7:0];
        `IDX_PBO: pbo_d = writedata_in[7:0];
        `IDX_FRAME_OUT: fout_d = writedata_in[7:0];
        `IDX_SYNC_CFG: scfg_d = writedata_in[7:0];
        `IDX_SYNC_WIN: swin_d = writedata_in[7:0];
        `IDX_SYNTH_CFG: syn_d = writedata_in[7:0];
        `IDX_PHASE_OFS: phofs_d[7:0] = writedata_in[7:0];
        default: sticky_d = sticky_d;
      endcase
    end
    if (wr && byteenable_in[1] && idx == `IDX_PHASE_OFS)
      phofs_d[15:8] = writedata_in[15:8];
    // set wins over clear
    if (fail_ev)
      sticky_d = 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      sticky_q <= 1'b0;
      diff_q <= `RST_DIFF_OUT;
      pbo_q <= `RST_PBO;
      fout_q <= `RST_FRAME_OUT;
      scfg_q <= `RST_SYNC_CFG;
      swin_q <= `RST_SYNC_WIN;
      syn_q <= `RST_SYNTH_CFG;
      phofs_q <= `RST_PHASE_OFS;
    end
    else
    begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      sticky_q <= sticky_d;
      diff_q <= diff_d;
      pbo_q <= pbo_d;
      fout_q <= fout_d;
      scfg_q <= scfg_d;
      swin_q <= swin_d;
      syn_q <= syn_d;
      phofs_q <= phofs_d;
    end
  end

  // ---------------- sampling and checks
  frame_sync_pkg::det_state_t det_q, det_d;
  logic ref_q, fa_ref_q, fa_ref_d, fa_s_q, fa_s_d;
  logic [3:0] res_cnt_q, res_cnt_d, res_cyc;
  logic [17:0] ivl_q, ivl_d;
  logic [3:0] good_q, good_d;
  logic live_d, fall, freq_ok, phase_ok, ivl_2k;
  logic resync_q, resync_d, mf_resync_q, mf_resync_d;
  logic [17:0] tol;

  always_comb
  begin
    // resolution period from sync phase bit and locked rate
    if (!scfg_q[`BIT_SYNC_PHASE])
      res_cyc = 4'(`CYC_RES_6M48);
    else if (ref_is_19m44_in)
      res_cyc = 4'(`CYC_RES_19M44);
    else
      res_cyc = 4'(`CYC_RES_38M88);
    tol = 18'({swin_q[`LSB_WIN +: 3], 1'b1}) * 18'(res_cyc);
    // latch on reference rising edge
    fa_ref_d = (ref_clk_in && !ref_q) ? frame_align_in : fa_ref_q;
    res_cnt_d = (res_cnt_q >= res_cyc - 4'h1) ? 4'h0 : res_cnt_q + 4'h1;
    fa_s_d = (res_cnt_q == 4'h0) ? fa_ref_q : fa_s_q;
    fall = fa_s_q && !fa_s_d && (res_cnt_q == 4'h0);
    freq_ok = (ivl_q + tol >= 18'(P8)) && (ivl_q <= 18'(P2) + tol);
    phase_ok = 1'b0;
    for (int k = 1; k <= `FRAMES_PER_2K; k = k * 2)
    begin
      if (ivl_q + tol >= 18'(P8 * k) && ivl_q <= 18'(P8 * k) + tol)
        phase_ok = 1'b1;
    end
    ivl_2k = ivl_q + tol >= 18'(P2);
    ivl_d = (ivl_q == 18'h3ffff) ? ivl_q : ivl_q + 18'h1;
    det_d = det_q;
    good_d = good_q;
    live_d = live_q;
    fail_ev = 1'b0;
    resync_d = 1'b0;
    mf_resync_d = 1'b0;
    if (fall)
    begin
      ivl_d = 18'h1;
      if (det_q == frame_sync_pkg::DET_ABSENT)
        det_d = frame_sync_pkg::DET_QUAL;
      else if (freq_ok && phase_ok)
      begin
        live_d = 1'b0;
        good_d = (good_q == 4'(QUAL_EDGES)) ? good_q : good_q + 4'h1;
        if (good_d == 4'(QUAL_EDGES))
          det_d = frame_sync_pkg::DET_PRESENT;
        if (det_q == frame_sync_pkg::DET_PRESENT)
        begin
          resync_d = 1'b1;
          mf_resync_d = ivl_2k;
        end
      end
      else
      begin
        fail_ev = 1'b1;
        live_d = 1'b1;
        good_d = 4'h0;
        det_d = frame_sync_pkg::DET_QUAL;
      end
    end
    else if (det_q != frame_sync_pkg::DET_ABSENT && ivl_q > 18'(P2) + tol)
    begin
      // input missing
      fail_ev = 1'b1;
      live_d = 1'b1;
      good_d = 4'h0;
      det_d = frame_sync_pkg::DET_ABSENT;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      det_q <= frame_sync_pkg::DET_ABSENT;
      ref_q <= 1'b0;
      fa_ref_q <= 1'b1;
      fa_s_q <= 1'b1;
      res_cnt_q <= 4'h0;
      ivl_q <= 18'h0;
      good_q <= 4'h0;
      live_q <= 1'b0;
      resync_q <= 1'b0;
      mf_resync_q <= 1'b0;
    end
    else
    begin
      det_q <= det_d;
      ref_q <= ref_clk_in;
      fa_ref_q <= fa_ref_d;
      fa_s_q <= fa_s_d;
      res_cnt_q <= res_cnt_d;
      ivl_q <= ivl_d;
      good_q <= good_d;
      live_q <= live_d;
      resync_q <= resync_d;
      mf_resync_q <= mf_resync_d;
    end
  end

  // ---------------- frame dividers and composite clock
  logic [13:0] fcnt_q, fcnt_d, load;
  logic [1:0] mf_q, mf_d;
  logic [10:0] scnt_q, scnt_d;
  logic [2:0] slot_q, slot_d;
  logic pol_q, pol_d, ap_q, ap_d, an_q, an_d;
  logic f8_q, f8_d, m2_q, m2_d, g8_q, g8_d, g2_q, g2_d;
  logic [13:0] half_res;
  logic slot_end;

  always_comb
  begin
    // expected arrival shift, code 1 is nominal
    half_res = 14'(res_cyc >> 1);
    load = 14'(P8) - half_res + 14'(scfg_q[1:0]) * half_res;
    if (load >= 14'(P8))
      load = load - 14'(P8);
    fcnt_d = (fcnt_q == 14'(P8 - 1)) ? 14'h0 : fcnt_q + 14'h1;
    mf_d = (fcnt_q == 14'(P8 - 1)) ? mf_q + 2'h1 : mf_q;
    if (resync_q)
    begin
      fcnt_d = load;
      if (mf_resync_q)
        mf_d = 2'h0;
    end
    f8_d = fcnt_d >= 14'(P8 / 2);
    m2_d = (mf_d != 2'h0) || f8_d;
    // dedicated pulses always main, general outputs selectable
    g8_d = fout_q[`BIT_AUX_FRAMES] ? aux_frame_8k_in : f8_d;
    g2_d = fout_q[`BIT_AUX_FRAMES] ? aux_mframe_2k_in : m2_d;
    // eight slots per frame: four short, four long
    slot_end = scnt_q == 11'(SLOT - 1 + int'(slot_q[0]));
    scnt_d = slot_end ? 11'h0 : scnt_q + 11'h1;
    slot_d = slot_end ? slot_q + 3'h1 : slot_q;
    pol_d = pol_q;
    if (fcnt_d == 14'h0)
    begin
      scnt_d = 11'h0;
      slot_d = 3'h0;
    end
    if (scnt_d == 11'h0 && slot_d != 3'h0)
      pol_d = !pol_q;
    // frame boundary repeats the last polarity
    ap_d = (scnt_d < 11'(SLOT / 2)) && pol_d;
    an_d = (scnt_d < 11'(SLOT / 2)) && !pol_d;
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      fcnt_q <= 14'h0;
      mf_q <= 2'h0;
      scnt_q <= 11'h0;
      slot_q <= 3'h0;
      pol_q <= 1'b0;
      ap_q <= 1'b0;
      an_q <= 1'b0;
      f8_q <= 1'b0;
      m2_q <= 1'b0;
      g8_q <= 1'b0;
      g2_q <= 1'b0;
    end
    else
    begin
      fcnt_q <= fcnt_d;
      mf_q <= mf_d;
      scnt_q <= scnt_d;
      slot_q <= slot_d;
      pol_q <= pol_d;
      ap_q <= ap_d;
      an_q <= an_d;
      f8_q <= f8_d;
      m2_q <= m2_d;
      g8_q <= g8_d;
      g2_q <= g2_d;
    end
  end

  // ---------------- synthesizers and path controls
  logic [31:0] acc_q, acc_d;
  logic oc_q, oc_d, fw_q, fw_d;
  logic lf_apll_q, lf_apll_d, apll_lf_q, apll_lf_d, pre_q, pre_d;
  logic [5:0] div_q, div_d;
  logic [31:0] fwd;

  always_comb
  begin
    // fixed increment: rate never depends on the reference
    acc_d = acc_q + SYNTH_INC;
    if (resync_q && !scfg_q[`BIT_INDEP] && scfg_q[`BIT_SYNC_OCN])
      acc_d = 32'h8000_0000;
    fwd = acc_d + {phofs_q, 16'h0000};
    oc_d = acc_d[31];
    fw_d = fwd[31];
    apll_lf_d = syn_q[`BIT_APLL_FROM_LF];
    // no loop: direct clock whenever apll fed from low-rate synth
    lf_apll_d = syn_q[`BIT_LF_FROM_APLL] && !syn_q[`BIT_APLL_FROM_LF];
    pre_d = syn_q[`BIT_PREDIV];
    div_d = frame_sync_pkg::div_ratio(syn_q[2:0]);
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      acc_q <= 32'h0000_0000;
      oc_q <= 1'b0;
      fw_q <= 1'b0;
      lf_apll_q <= 1'b0;
      apll_lf_q <= 1'b0;
      pre_q <= 1'b0;
      div_q <= 6'h01;
    end
    else
    begin
      acc_q <= acc_d;
      oc_q <= oc_d;
      fw_q <= fw_d;
      lf_apll_q <= lf_apll_d;
      apll_lf_q <= apll_lf_d;
      pre_q <= pre_d;
      div_q <= div_d;
    end
  end

  assign readdata_out = rdata_q;
  assign waitrequest_out = wait_q;
  assign frame_pulse_8k_out = f8_q;
  assign multiframe_pulse_2k_out = m2_q;
  assign gco_frame_8k_out = g8_q;
  assign gco_mframe_2k_out = g2_q;
  assign ami_pos_out = ap_q;
  assign ami_neg_out = an_q;
  assign optical_clk_out = oc_q;
  assign forward_clk_out = fw_q;
  assign diff_std_out = diff_q[1:0];
  assign pbo_enable_out = pbo_q[`BIT_PBO_EN];
  assign pfd_prediv_out = pre_q;
  assign lf_from_apll_out = lf_apll_q;
  assign apll_from_lf_out = apll_lf_q;
  assign apll_div_out = div_q;
  assign alarm_out = live_q;
endmodule

// ### tb/frame_sync_resync_properties.sv
// concurrent checks on the frame sync resync top ports
// assumes a bind onto the design top and a single clock domain
`include "frame_sync_consts.svh"
module frame_sync_resync_properties (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // register bus
  input wire logic [9:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  input wire logic waitrequest_out,
  // watched outputs
  input wire logic frame_pulse_8k_out,
  input wire logic multiframe_pulse_2k_out,
  input wire logic ami_pos_out,
  input wire logic ami_neg_out,
  input wire logic [1:0] diff_std_out,
  input wire logic pbo_enable_out,
  input wire logic lf_from_apll_out,
  input wire logic apll_from_lf_out,
  input wire logic [5:0] apll_div_out
);
  localparam int HALF_FRAME = `CYC_FRAME_8K / 2;
  logic [15:0] high_q;
  logic [31:0] wdata_q;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // length of the current high run of the frame pulse, last accepted write data
  always_ff @(posedge clock_in)
  begin
    if (srst_in || !frame_pulse_8k_out)
      high_q <= 16'h0000;
    else
      high_q <= high_q + 16'h0001;
    if (write_in && !waitrequest_out)
      wdata_q <= writedata_in;
  end
  sequence req_taken;
    (read_in || write_in) && waitrequest_out;
  endsequence
  sequence write_done(logic [7:0] idx);
    write_in && !waitrequest_out && (address_in[9:2] == idx) && byteenable_in[0];
  endsequence
  bus_answer_a:
    assert property (req_taken |=> !waitrequest_out)
      else $error("bus request not answered after one cycle");
  wait_pulse_a:
    assert property (!waitrequest_out |=> waitrequest_out)
      else $error("waitrequest low longer than one cycle");
  diff_std_a:
    assert property (write_done(`IDX_DIFF_OUT) |=> ##[0:1] diff_std_out == wdata_q[1:0])
      else $error("output standard does not follow its register");
  pbo_follow_a:
    assert property (write_done(`IDX_PBO) |=> ##[0:1] pbo_enable_out == wdata_q[2])
      else $error("build-out enable does not follow its register");
  frame_half_a:
    assert property (high_q <= HALF_FRAME)
      else $error("frame pulse high longer than half a frame");
  mframe_inside_a:
    assert property (!multiframe_pulse_2k_out |-> !frame_pulse_8k_out)
      else $error("multiframe pulse low outside first half of frame");
  ami_excl_a:
    assert property (!(ami_pos_out && ami_neg_out))
      else $error("both composite marks active");
  no_loop_a:
    assert property (apll_from_lf_out |-> !lf_from_apll_out)
      else $error("low rate synth fed from apll while driving it");
  div_legal_a:
    assert property (apll_div_out inside {6'h01, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h30})
      else $error("illegal output divide ratio");
endmodule

// ### tb/sync_master_model.sv
// master timing device: free running reference and 8k frame-align pulses
// assumes the bench enables it and may request one early edge
module sync_master_model (
  // control
  input wire logic enable_in,
  input wire logic early_in,
  // link
  output logic ref_clk_out,
  output logic frame_align_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  int limit;
  initial ref_clk_out = 1'b0;
  initial frame_align_out = 1'b1;
  // about 6.48 MHz, 810 cycles make one 8k frame
  always #77.160 ref_clk_out = ~ref_clk_out;
  // edges launched on the falling reference edge, sampled on the rising one
  always @(negedge ref_clk_out)
  begin
    limit = early_in ? 300 : 810;
    if (!enable_in)
    begin
      cnt <= 0;
      frame_align_out <= 1'b1;
    end
    else
    begin
      cnt <= (cnt + 1 >= limit) ? 0 : cnt + 1;
      if (cnt == 0)
        frame_align_out <= 1'b0;
      else if (cnt == 150)
        frame_align_out <= 1'b1;
    end
  end
endmodule

// ### tb/frame_sync_resync_tb.sv
// self-checking bench for the frame sync resync block
// assumes the master model on the sync link and a 100 MHz clock
module frame_sync_resync_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] RATIO [8] = '{6'h01, 6'h02, 6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h30};
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [9:0] address_in = 10'h000;
  logic read_in = 1'b0;
  logic write_in = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic ref_is_19m44_in = 1'b0;
  logic aux_frame_8k_in = 1'b0;
  logic aux_mframe_2k_in = 1'b0;
  logic sync_en = 1'b0;
  logic early = 1'b0;
  logic [31:0] readdata_out;
  logic waitrequest_out, ref_clk_in, frame_align_in, frame_pulse_8k_out, multiframe_pulse_2k_out;
  logic gco_frame_8k_out, gco_mframe_2k_out, ami_pos_out, ami_neg_out, optical_clk_out;
  logic forward_clk_out, pbo_enable_out, pfd_prediv_out, lf_from_apll_out, apll_from_lf_out;
  logic alarm_out;
  logic [1:0] diff_std_out;
  logic [5:0] apll_div_out;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 clock_in = ~clock_in;
  frame_sync_resync #(.QUAL_EDGES(1)) i_dut (.clock_in(clock_in), .srst_in(srst_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .byteenable_in(4'hf), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .ref_clk_in(ref_clk_in),
    .ref_is_19m44_in(ref_is_19m44_in), .frame_align_in(frame_align_in),
    .aux_frame_8k_in(aux_frame_8k_in), .aux_mframe_2k_in(aux_mframe_2k_in),
    .frame_pulse_8k_out(frame_pulse_8k_out), .multiframe_pulse_2k_out(multiframe_pulse_2k_out),
    .gco_frame_8k_out(gco_frame_8k_out), .gco_mframe_2k_out(gco_mframe_2k_out),
    .ami_pos_out(ami_pos_out), .ami_neg_out(ami_neg_out), .optical_clk_out(optical_clk_out),
    .forward_clk_out(forward_clk_out), .diff_std_out(diff_std_out),
    .pbo_enable_out(pbo_enable_out), .pfd_prediv_out(pfd_prediv_out),
    .lf_from_apll_out(lf_from_apll_out), .apll_from_lf_out(apll_from_lf_out),
    .apll_div_out(apll_div_out), .alarm_out(alarm_out));
  sync_master_model i_master (.enable_in(sync_en), .early_in(early), .ref_clk_out(ref_clk_in),
    .frame_align_out(frame_align_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock_in);
    read_in <= !we;
    write_in <= we;
    address_in <= {idx, 2'b00};
    writedata_in <= wd;
    do @(posedge clock_in); while (waitrequest_out !== 1'b0);
    rd = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 32'h0, rd);
    check(rd & mask, exp, "register read");
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
    repeat (2) @(posedge clock_in);
  endtask
  task automatic test_reset_values;
    logic [7:0] idx [7] = '{8'h3a, 8'h48, 8'h7a, 8'h7b, 8'h7c, 8'h50, 8'h01};
    logic [7:0] val [7] = '{8'h02, 8'h04, 8'h00, 8'h01, 8'h20, 8'h00, 8'h00};
    check(diff_std_out, 32'h2, "standard after reset");
    check(apll_div_out, 32'h1, "divide after reset");
    check(alarm_out, 32'h0, "alarm after reset");
    for (int i = 0; i < 7; i++)
      rd_chk(idx[i], 32'hffffffff, {24'h0, val[i]});
    $display("test reset_values done");
  endtask
  task automatic test_controls;
    wr(8'h3a, 32'h1);
    check(diff_std_out, 32'h1, "output standard");
    rd_chk(8'h3a, 32'hff, 32'h1);
    wr(8'h48, 32'h0);
    check(pbo_enable_out, 32'h0, "build-out off");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h50, 32'(i) | (i[0] ? 32'h20 : 32'h0));
      check(apll_div_out, RATIO[i], "divide ratio");
      check(pfd_prediv_out, i[0], "pre-divider");
    end
    wr(8'h51, 32'h8000);
    check(forward_clk_out ^ optical_clk_out, 32'h1, "half cycle offset");
    wr(8'h51, 32'h0);
    check(forward_clk_out ^ optical_clk_out, 32'h0, "zero offset");
    wr(8'h50, 32'h18);
    check({apll_from_lf_out, lf_from_apll_out}, 32'h2, "loop guard");
    wr(8'h50, 32'h10);
    check({apll_from_lf_out, lf_from_apll_out}, 32'h1, "filtered feed");
    wr(8'h01, 32'hffffffff);
    rd_chk(8'h01, 32'hffffffff, 32'h0);
    $display("test controls done");
  endtask
  task automatic test_aux_select;
    wr(8'h7a, 32'h80);
    aux_frame_8k_in <= 1'b1;
    aux_mframe_2k_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    check({gco_frame_8k_out, gco_mframe_2k_out}, 32'h3, "aux pulses high");
    aux_frame_8k_in <= 1'b0;
    aux_mframe_2k_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    check({gco_frame_8k_out, gco_mframe_2k_out}, 32'h0, "aux pulses low");
    wr(8'h7a, 32'h0);
    $display("test aux_select done");
  endtask
  task automatic test_resync;
    int n;
    logic prev;
    sync_en <= 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      @(negedge frame_align_in);
      n = 0;
      prev = frame_pulse_8k_out;
      while (!(prev === 1'b1 && frame_pulse_8k_out === 1'b0) && n < 13000)
      begin
        prev = frame_pulse_8k_out;
        @(negedge clock_in);
        n++;
      end
    end
    early <= 1'b1;
    check(n <= 40, 32'h1, "frame boundary follows input edge");
    wr(8'h08, 32'h80);
    rd_chk(8'h08, 32'h80, 32'h0);
    check(alarm_out, 32'h0, "alarm while locked");
    @(negedge frame_align_in);
    early <= 1'b0;
    repeat (200) @(posedge clock_in);
    rd_chk(8'h08, 32'h80, 32'h80);
    check(alarm_out, 32'h1, "alarm after bad edge");
    $display("test resync done");
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      errors++;
      $display("mismatch at %0t: run did not finish in time", $time);
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    test_reset_values();
    test_controls();
    test_aux_select();
    test_resync();
    complete_run();
  end
endmodule
bind frame_sync_resync frame_sync_resync_properties i_props (.clock_in(clock_in),
  .srst_in(srst_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in),
  .waitrequest_out(waitrequest_out), .frame_pulse_8k_out(frame_pulse_8k_out),
  .multiframe_pulse_2k_out(multiframe_pulse_2k_out), .ami_pos_out(ami_pos_out),
  .ami_neg_out(ami_neg_out), .diff_std_out(diff_std_out), .pbo_enable_out(pbo_enable_out),
  .lf_from_apll_out(lf_from_apll_out), .apll_from_lf_out(apll_from_lf_out),
  .apll_div_out(apll_div_out));
